// ===== core/palette_register_interface.sv
// host register bank, colour table and masked pixel lookup of the palette
//
// Overview of operation
// - one address register, reached through select codes 0,0 and 1,1.
// - write at 0,0 loads address and restarts the colour byte sequence.
// - write at 1,1 loads address, fetches that entry, then increments.
// - reads at 0,0 and 1,1 both return the address register.
// - 24-bit colour buffer moves as three byte transfers at select 0,1.
// - narrow mode keeps only the six low data bits of each written byte.
// - full mode uses all eight bits for reads and writes, bit seven highest.
// - third written byte stores the buffer into the table, then increments.
// - third read byte reloads the buffer from the table, then increments.
// - each buffer/table transfer replaces one pixel lookup.
// - pixel mask at select 1,0 ANDs each incoming pixel address bit.
// - pixel mask never affects the host-side table address.
// - any address update aborts a partial colour sequence.
// - select lines are sampled at the falling edge of the active strobe.
// - write data is captured at the rising edge of the write strobe.
// - width select high gives 8-bit colour, low gives 6-bit colour.
`include "pri_params.svh"
module pri_palette_register_interface (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic register_select_low,
  input wire logic register_select_high,
  input wire logic [7:0] program_data_bus_in,
  output logic [7:0] program_data_bus_out,
  output logic program_data_bus_oe,
  input wire logic width_select_full,
  input wire logic [7:0] pixel_address_inputs,
  output pri_pkg::pri_colour_t pixel_colour,
  output logic host_slot
);
  import pri_pkg::*;

  function automatic logic [7:0] pri_fit(input logic [7:0] d, input logic full);
    pri_fit = full ? d : (d & `PRI_NARROW_KEEP);
  endfunction : pri_fit

  function automatic logic [7:0] pri_get(input pri_colour_t c, input pri_byte_idx_t i);
    unique case (i)
      2'h0: pri_get = c[`PRI_RED_LSB +: 8];
      2'h1: pri_get = c[`PRI_GREEN_LSB +: 8];
      default: pri_get = c[`PRI_BLUE_LSB +: 8];
    endcase
  endfunction : pri_get

  function automatic pri_colour_t pri_put(input pri_colour_t c, input pri_byte_idx_t i,
                                          input logic [7:0] b);
    pri_colour_t r;
    r = c;
    unique case (i)
      2'h0: r[`PRI_RED_LSB +: 8] = b;
      2'h1: r[`PRI_GREEN_LSB +: 8] = b;
      default: r[`PRI_BLUE_LSB +: 8] = b;
    endcase
    pri_put = r;
  endfunction : pri_put

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only
  logic [12:0] sync1_ff;
  logic [12:0] sync2_ff;
  logic [12:0] nxt_sync1;
  logic [12:0] nxt_sync2;
  logic wr_n_s;
  logic rd_n_s;
  logic [1:0] rs_s;
  logic [7:0] data_s;
  logic full_s;

  always_comb begin
    nxt_sync1 = {write_strobe_n, read_strobe_n, register_select_high, register_select_low,
                 program_data_bus_in, width_select_full};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_ff <= 13'h1800;
      sync2_ff <= 13'h1800;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  assign wr_n_s = sync2_ff[12];
  assign rd_n_s = sync2_ff[11];
  assign rs_s = sync2_ff[10:9];
  assign data_s = sync2_ff[8:1];
  assign full_s = sync2_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // host register bank
  logic wr_prev_ff;
  logic rd_prev_ff;
  logic [1:0] sel_ff;
  logic [7:0] addr_ff;
  pri_colour_t cvb_ff;
  pri_byte_idx_t idx_ff;
  logic [7:0] mask_ff;
  logic [7:0] dout_ff;
  logic oe_ff;
  logic [1:0] nxt_sel;
  logic [7:0] nxt_addr;
  pri_colour_t nxt_cvb;
  pri_byte_idx_t nxt_idx;
  logic [7:0] nxt_mask;
  logic [7:0] nxt_dout;
  logic nxt_oe;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic lut_we;
  logic xfer;
  pri_colour_t lut [`PRI_TABLE_DEPTH];

  assign wr_fall = wr_prev_ff & ~wr_n_s;
  assign wr_rise = ~wr_prev_ff & wr_n_s;
  assign rd_fall = rd_prev_ff & ~rd_n_s;
  assign rd_rise = ~rd_prev_ff & rd_n_s;

  always_comb begin
    nxt_sel = sel_ff;
    nxt_addr = addr_ff;
    nxt_cvb = cvb_ff;
    nxt_idx = idx_ff;
    nxt_mask = mask_ff;
    nxt_dout = dout_ff;
    nxt_oe = oe_ff;
    lut_we = 1'b0;
    xfer = 1'b0;
    if (wr_fall || rd_fall) begin
      nxt_sel = rs_s;
    end
    if (rd_fall) begin
      nxt_oe = 1'b1;
      unique case (rs_s)
        `PRI_SEL_ADDR_WRITE, `PRI_SEL_ADDR_READ: nxt_dout = addr_ff;
        `PRI_SEL_COLOUR: nxt_dout = pri_fit(pri_get(cvb_ff, idx_ff), full_s);
        `PRI_SEL_MASK: nxt_dout = mask_ff;
      endcase
    end
    if (rd_rise) begin
      nxt_oe = 1'b0;
      if (sel_ff == `PRI_SEL_COLOUR) begin
        if (idx_ff == `PRI_LAST_BYTE) begin
          nxt_cvb = lut[addr_ff];
          nxt_addr = addr_ff + 8'h01;
          nxt_idx = 2'h0;
          xfer = 1'b1;
        end else begin
          nxt_idx = idx_ff + 2'h1;
        end
      end
    end
    if (wr_rise) begin
      unique case (sel_ff)
        `PRI_SEL_ADDR_WRITE: begin
          nxt_addr = data_s;
          nxt_idx = 2'h0;
        end
        `PRI_SEL_ADDR_READ: begin
          nxt_cvb = lut[data_s];
          nxt_addr = data_s + 8'h01;
          nxt_idx = 2'h0;
          xfer = 1'b1;
        end
        `PRI_SEL_COLOUR: begin
          nxt_cvb = pri_put(cvb_ff, idx_ff, pri_fit(data_s, full_s));
          if (idx_ff == `PRI_LAST_BYTE) begin
            lut_we = 1'b1;
            nxt_addr = addr_ff + 8'h01;
            nxt_idx = 2'h0;
            xfer = 1'b1;
          end else begin
            nxt_idx = idx_ff + 2'h1;
          end
        end
        `PRI_SEL_MASK: nxt_mask = data_s;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      sel_ff <= `PRI_SEL_ADDR_WRITE;
      addr_ff <= `PRI_ADDR_RESET;
      cvb_ff <= `PRI_COLOUR_RESET;
      idx_ff <= 2'h0;
      mask_ff <= `PRI_MASK_RESET;
      dout_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      wr_prev_ff <= wr_n_s;
      rd_prev_ff <= rd_n_s;
      sel_ff <= nxt_sel;
      addr_ff <= nxt_addr;
      cvb_ff <= nxt_cvb;
      idx_ff <= nxt_idx;
      mask_ff <= nxt_mask;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  // table contents have no reset
  always_ff @(posedge sys_clk) begin
    if (lut_we) begin
      lut[addr_ff] <= nxt_cvb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel lookup through the mask
  pri_colour_t pix_ff;
  logic slot_ff;
  pri_colour_t nxt_pix;
  logic nxt_slot;

  always_comb begin
    nxt_slot = xfer;
    nxt_pix = xfer ? pix_ff : lut[pixel_address_inputs & mask_ff];
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pix_ff <= `PRI_COLOUR_RESET;
      slot_ff <= 1'b0;
    end else begin
      pix_ff <= nxt_pix;
      slot_ff <= nxt_slot;
    end
  end

  assign pixel_colour = pix_ff;
  assign host_slot = slot_ff;
  assign program_data_bus_out = dout_ff;
  assign program_data_bus_oe = oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_read_mode_load;
    @(posedge sys_clk) disable iff (reset)
    (wr_rise && sel_ff == `PRI_SEL_ADDR_READ) |=> addr_ff == $past(data_s) + 8'h01 && slot_ff;
  endproperty
  a_read_mode_load: assert property (p_read_mode_load) else $error("read mode load wrong");

  property p_addr_abort;
    @(posedge sys_clk) disable iff (reset)
    (wr_rise && (sel_ff == `PRI_SEL_ADDR_WRITE || sel_ff == `PRI_SEL_ADDR_READ)) |=> idx_ff == 2'h0;
  endproperty
  a_addr_abort: assert property (p_addr_abort) else $error("sequence not aborted");

  property p_third_write;
    @(posedge sys_clk) disable iff (reset)
    (wr_rise && sel_ff == `PRI_SEL_COLOUR && idx_ff == `PRI_LAST_BYTE)
      |=> addr_ff == $past(addr_ff) + 8'h01 && lut[$past(addr_ff)] == cvb_ff;
  endproperty
  a_third_write: assert property (p_third_write) else $error("third write not stored");

  property p_slot_holds;
    @(posedge sys_clk) disable iff (reset)
    slot_ff |-> pix_ff === $past(pix_ff) ##1 !slot_ff;
  endproperty
  a_slot_holds: assert property (p_slot_holds) else $error("pixel slot not replaced");

  property p_addr_read;
    @(posedge sys_clk) disable iff (reset)
    (rd_fall && rs_s[0] == rs_s[1]) |=> program_data_bus_out == $past(addr_ff) && program_data_bus_oe;
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("address read wrong");

  property p_narrow_write;
    @(posedge sys_clk) disable iff (reset)
    (wr_rise && sel_ff == `PRI_SEL_COLOUR && idx_ff == 2'h0 && !full_s) |=> cvb_ff[23:22] == 2'h0;
  endproperty
  a_narrow_write: assert property (p_narrow_write) else $error("narrow write kept top bits");

  property p_wrap;
    @(posedge sys_clk) disable iff (reset)
    ($past(addr_ff) == 8'hff && xfer && sel_ff == `PRI_SEL_COLOUR) ##1 1'b1 |-> addr_ff == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_mask_write;
    @(posedge sys_clk) disable iff (reset)
    (wr_rise && sel_ff == `PRI_SEL_MASK) |=> mask_ff == $past(data_s) ##1 $stable(addr_ff);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write wrong");

  property p_idx_range;
    @(posedge sys_clk) disable iff (reset)
    idx_ff != 2'h3;
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("byte index out of range");
endmodule : pri_palette_register_interface

// ===== include/pri_params.svh
// constants of the palette register interface
`ifndef PRI_PARAMS_SVH
`define PRI_PARAMS_SVH
`define PRI_SEL_ADDR_WRITE 2'b00
`define PRI_SEL_COLOUR 2'b01
`define PRI_SEL_MASK 2'b10
`define PRI_SEL_ADDR_READ 2'b11
`define PRI_RED_LSB 16
`define PRI_GREEN_LSB 8
`define PRI_BLUE_LSB 0
`define PRI_LAST_BYTE 2'h2
`define PRI_NARROW_KEEP 8'h3f
`define PRI_ADDR_RESET 8'h00
`define PRI_MASK_RESET 8'hff
`define PRI_COLOUR_RESET 24'h000000
`define PRI_TABLE_DEPTH 256
`endif

// ===== include/pri_pkg.sv
// types of the palette register interface
`include "pri_params.svh"
package pri_pkg;
  typedef enum logic [1:0] {
    PRI_ADDR_WRITE = `PRI_SEL_ADDR_WRITE,
    PRI_COLOUR = `PRI_SEL_COLOUR,
    PRI_MASK = `PRI_SEL_MASK,
    PRI_ADDR_READ = `PRI_SEL_ADDR_READ
  } pri_sel_e;
  typedef logic [1:0] pri_byte_idx_t;
  typedef logic [23:0] pri_colour_t;
endpackage : pri_pkg

// ===== sim/pri_host_model.sv
// host processor model driving the palette register bus
module pri_host_model (
  input wire logic sys_clk,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic register_select_low,
  output logic register_select_high,
  output logic [7:0] host_data,
  input wire logic [7:0] bus_level,
  input wire logic program_data_bus_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles held around each strobe edge; raised by the bench for a slow host
  int gap = 4;
  initial begin
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    register_select_low = 1'b0;
    register_select_high = 1'b0;
    host_data = 8'h00;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : hold
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    {register_select_high, register_select_low} = sel;
    host_data = d;
    hold(gap);
    write_strobe_n = 1'b0;
    hold(gap);
    write_strobe_n = 1'b1;
    hold(gap);
    // released bus shows a changed pattern, not the last value
    host_data = ~d;
    hold(1);
  endtask : wr
  task automatic rd(input logic [1:0] sel, output logic [7:0] d);
    int n;
    n = 0;
    {register_select_high, register_select_low} = sel;
    hold(gap);
    read_strobe_n = 1'b0;
    while (program_data_bus_oe !== 1'b1 && n < 16) begin
      hold(1);
      n++;
    end
    hold(gap);
    // an undriven bus must never pass for read data
    d = (program_data_bus_oe === 1'b1) ? bus_level : 8'hxx;
    hold(1);
    read_strobe_n = 1'b1;
    hold(gap + 4);
  endtask : rd
endmodule : pri_host_model

// ===== sim/test_palette_register_interface.sv
// self-checking bench of the palette register interface
module test_palette_register_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic write_strobe_n, read_strobe_n, register_select_low, register_select_high;
  logic [7:0] host_data, program_data_bus_out, rb, a, m, p;
  logic [7:0] pixel_address_inputs = 8'h00;
  logic [7:0] slots = 8'h00;
  logic [7:0] exp_slots = 8'h00;
  logic program_data_bus_oe, host_slot;
  logic width_select_full = 1'b1;
  logic [23:0] pixel_colour, c;
  logic [23:0] tab [256];
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 32'h5fe6c313;
  wire logic [7:0] bus = program_data_bus_oe ? program_data_bus_out : host_data;

  initial forever #4 sys_clk = ~sys_clk;

  pri_palette_register_interface u_dut (.sys_clk(sys_clk), .reset(reset),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .register_select_low(register_select_low), .register_select_high(register_select_high),
    .program_data_bus_in(bus), .program_data_bus_out(program_data_bus_out),
    .program_data_bus_oe(program_data_bus_oe), .width_select_full(width_select_full),
    .pixel_address_inputs(pixel_address_inputs), .pixel_colour(pixel_colour),
    .host_slot(host_slot));
  pri_host_model u_host (.sys_clk(sys_clk), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .register_select_low(register_select_low),
    .register_select_high(register_select_high), .host_data(host_data),
    .bus_level(bus), .program_data_bus_oe(program_data_bus_oe));

  always @(posedge sys_clk) if (host_slot === 1'b1) slots <= slots + 8'h01;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk24
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    chk24({16'h0000, got}, {16'h0000, exp});
  endtask : chk8
  function automatic logic [7:0] keep(input logic [7:0] b);
    return width_select_full ? b : (b & 8'h3f);
  endfunction : keep
  task automatic wcol(input logic [7:0] ad, input logic [23:0] cv);
    u_host.wr(2'b00, ad);
    for (int k = 2; k >= 0; k--) u_host.wr(2'b01, cv[k*8 +: 8]);
    tab[ad] = {keep(cv[23:16]), keep(cv[15:8]), keep(cv[7:0])};
    exp_slots++;
  endtask : wcol
  task automatic rcol(input logic [7:0] ad);
    u_host.wr(2'b11, ad);
    for (int k = 2; k >= 0; k--) begin
      u_host.rd(2'b01, rb);
      chk8(rb, tab[ad][k*8 +: 8]);
    end
    exp_slots += 8'h02;
  endtask : rcol
  task automatic achk(input logic [7:0] exp);
    u_host.rd(2'b00, rb);
    chk8(rb, exp);
    u_host.rd(2'b11, rb);
    chk8(rb, exp);
  endtask : achk
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    u_host.hold(4);
    achk(8'h00);
    u_host.rd(2'b10, rb);
    chk8(rb, 8'hff);
    for (int i = 0; i < 8; i++) begin
      width_select_full = i[0];
      u_host.gap = 4 + 3 * i[1];
      a = (i == 0) ? 8'hff : 8'($random(seed));
      m = 8'($random(seed)) | a;
      p = 8'($random(seed));
      c = 24'($random(seed));
      wcol(a, c);
      achk(a + 8'h01);
      u_host.wr(2'b10, m);
      pixel_address_inputs = a | (p & ~m);
      u_host.hold(3);
      chk24(pixel_colour, tab[a]);
      // a cleared mask must leave host table accesses alone
      u_host.wr(2'b10, 8'h00);
      rcol(a);
      achk(a + 8'h02);
    end
    // partial sequences cut short by address updates
    a = 8'($random(seed));
    c = 24'($random(seed));
    u_host.wr(2'b00, a);
    u_host.wr(2'b01, 8'h5a);
    wcol(a, c);
    u_host.wr(2'b11, a);
    u_host.rd(2'b01, rb);
    exp_slots++;
    rcol(a);
    chk8(slots, exp_slots);
    print_verdict();
  end
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
endmodule : test_palette_register_interface
